// file: lcc_far.sv
// System-side framer model: random transmit symbols and a tally of error pulses.
`timescale 1ns/10ps
module lcc_far (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Channel outputs watched by the framer.
  input wire logic bit_strobe,
  input wire logic neg_rail_or_violation_out,
  // Transmit data towards the channel.
  output logic tx_pos_data_in,
  output logic tx_neg_data_in,
  // Error pulses seen so far.
  output int err_count
);
  int seed = 10524;
  int r;
  logic last;
  // A new dual-rail symbol each bit; both rails are never high together.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pos_data_in <= 1'b0;
      tx_neg_data_in <= 1'b0;
    end else if (bit_strobe) begin
      r = $random(seed);
      tx_pos_data_in <= r[0];
      tx_neg_data_in <= r[1] & ~r[0];
    end
  end
  // The channel keeps no tally, so the framer counts rising edges itself.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last <= 1'b0;
      err_count <= 0;
    end else begin
      last <= neg_rail_or_violation_out;
      if (neg_rail_or_violation_out && !last) err_count <= err_count + 1;
    end
  end
endmodule

// file: lcc_pkg.sv
// Shared constants and types for the line channel control block.
package lcc_pkg;

  // Register indices and their byte addresses on the APB word grid.
  localparam logic [7:0] CHAN_CFG_IDX = 8'h06;
  localparam logic [7:0] IRQ_STAT_IDX = 8'h08;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h09;
  localparam logic [7:0] LIVE_IDX = 8'h0A;
  localparam logic [7:0] WORD_BYTES = 8'h04;
  localparam logic [7:0] CHAN_CFG_ADDR = CHAN_CFG_IDX * WORD_BYTES;
  localparam logic [7:0] IRQ_STAT_ADDR = IRQ_STAT_IDX * WORD_BYTES;
  localparam logic [7:0] IRQ_MASK_ADDR = IRQ_MASK_IDX * WORD_BYTES;
  localparam logic [7:0] LIVE_ADDR = LIVE_IDX * WORD_BYTES;

  // Channel configuration field positions; bits above the top field read zero.
  localparam int unsigned CFG_W = 6;
  localparam int unsigned BIT_RAIL = 0;
  localparam int unsigned BIT_STS1 = 1;
  localparam int unsigned BIT_E3 = 2;
  localparam int unsigned BIT_LOCAL_LOOP = 3;
  localparam int unsigned BIT_REMOTE_LOOP = 4;
  localparam int unsigned BIT_PAT = 5;
  localparam logic [CFG_W-1:0] CFG_RESET = 6'h00;

  // Interrupt status and mask field positions.
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_PAT_ERR = 0;
  localparam int unsigned IRQ_VIOL = 1;
  localparam int unsigned IRQ_LOCK_CHG = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  // Live state register field positions.
  localparam int unsigned LIVE_LOCK = 0;
  localparam int unsigned LIVE_HOST = 1;
  localparam int unsigned LIVE_PAT_ACT = 2;

  // Pseudo-random sequence taps and seed.
  localparam int unsigned LFSR_W = 23;
  localparam int unsigned P15_TAP_A = 14;
  localparam int unsigned P15_TAP_B = 13;
  localparam int unsigned P23_TAP_A = 22;
  localparam int unsigned P23_TAP_B = 17;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 23'h7FFFFF;

  // Synchronised pin positions.
  localparam int unsigned NPIN = 6;
  localparam int unsigned PIN_TXP = 0;
  localparam int unsigned PIN_TXN = 1;
  localparam int unsigned PIN_RXP = 2;
  localparam int unsigned PIN_RXN = 3;
  localparam int unsigned PIN_VIOL = 4;
  localparam int unsigned PIN_HOST = 5;

  // Line rate and loop-back selections.
  typedef enum logic [1:0] {RATE_DS3, RATE_STS1, RATE_E3} lcc_rate_e;
  typedef enum logic [1:0] {LOOP_NONE, LOOP_REMOTE, LOOP_ANALOG, LOOP_DIGITAL} lcc_loop_e;
  typedef enum logic {SYNC_SEARCH, SYNC_LOCKED} lcc_sync_e;

endpackage

// file: lcc_prbs.sv
// Pseudo-random pattern generator and self-synchronising checker.
`timescale 1ns/10ps
module lcc_prbs #(
  parameter int unsigned LOCK_BITS = 32
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Control.
  input wire logic enable,
  input wire logic long_seq,
  input wire logic bit_tick,
  // Pattern data.
  output logic gen_bit,
  input wire logic rx_bit,
  output logic err_q,
  output logic locked
);

  initial begin
    if (LOCK_BITS < 2 || LOCK_BITS > 255) begin
      $error("lcc_prbs: LOCK_BITS must lie between 2 and 255");
    end
  end

  logic [lcc_pkg::LFSR_W-1:0] gen_q;
  logic [lcc_pkg::LFSR_W-1:0] chk_q;
  logic [7:0] good_q;
  lcc_pkg::lcc_sync_e sync_q;
  logic gen_fb;
  logic expect_bit;
  logic mismatch;

  // Feedback taps follow the selected sequence length.
  always_comb begin
    if (long_seq) begin
      gen_fb = gen_q[lcc_pkg::P23_TAP_A] ^ gen_q[lcc_pkg::P23_TAP_B];
      expect_bit = chk_q[lcc_pkg::P23_TAP_A] ^ chk_q[lcc_pkg::P23_TAP_B];
    end else begin
      gen_fb = gen_q[lcc_pkg::P15_TAP_A] ^ gen_q[lcc_pkg::P15_TAP_B];
      expect_bit = chk_q[lcc_pkg::P15_TAP_A] ^ chk_q[lcc_pkg::P15_TAP_B];
    end
  end

  assign gen_bit = gen_fb;
  assign mismatch = expect_bit ^ rx_bit;
  assign locked = (sync_q == lcc_pkg::SYNC_LOCKED);

  // Generator register; reseeded while disabled so it never sticks at zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_q <= lcc_pkg::LFSR_SEED;
    end else if (!enable) begin
      gen_q <= lcc_pkg::LFSR_SEED;
    end else if (bit_tick) begin
      gen_q <= {gen_q[lcc_pkg::LFSR_W-2:0], gen_fb};
    end
  end

  // Checker shift register loads the received bits it predicts from.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_q <= '0;
    end else if (enable && bit_tick) begin
      chk_q <= {chk_q[lcc_pkg::LFSR_W-2:0], rx_bit};
    end
  end

  // Error indication only while locked, one bit period long.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
    end else if (!enable) begin
      err_q <= 1'b0;
    end else if (bit_tick) begin
      err_q <= mismatch && locked;
    end
  end

  // Lock after enough consecutive matches; lose lock after as many consecutive mismatches.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_q <= lcc_pkg::SYNC_SEARCH;
      good_q <= 8'h00;
    end else if (!enable) begin
      sync_q <= lcc_pkg::SYNC_SEARCH;
      good_q <= 8'h00;
    end else if (bit_tick) begin
      case (sync_q)
        lcc_pkg::SYNC_SEARCH: begin
          if (mismatch) begin
            good_q <= 8'h00;
          end else if (good_q == 8'(LOCK_BITS - 1)) begin
            sync_q <= lcc_pkg::SYNC_LOCKED;
            good_q <= 8'h00;
          end else begin
            good_q <= good_q + 8'h01;
          end
        end
        lcc_pkg::SYNC_LOCKED: begin
          if (mismatch) begin
            if (good_q == 8'(LOCK_BITS - 1)) begin
              sync_q <= lcc_pkg::SYNC_SEARCH;
              good_q <= 8'h00;
            end else begin
              good_q <= good_q + 8'h01;
            end
          end else begin
            good_q <= 8'h00;
          end
        end
        default: begin
          sync_q <= lcc_pkg::SYNC_SEARCH;
        end
      endcase
    end
  end

endmodule

// file: lcc_sva.sv
// Concurrent checks on the ports of the line channel control block.
`timescale 1ns/10ps
module lcc_sva #(
  parameter int unsigned DIV_DS3 = 3,
  parameter int unsigned DIV_STS1 = 2,
  parameter int unsigned DIV_E3 = 4
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Line side.
  input wire logic line_tx_pos,
  input wire logic line_tx_neg,
  input wire logic codec_enable,
  input wire logic analog_loop_enable,
  input wire logic bit_strobe
);
  logic [5:0] cfg_q;
  logic [3:0] quiet_q;
  logic [3:0] gap_q;
  logic map;
  logic [3:0] div;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Mirror of the configuration and the cycles since it last changed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= 6'h00;
      quiet_q <= 4'h0;
    end else if (psel && penable && pready && pwrite && !pslverr &&
                 paddr == lcc_pkg::CHAN_CFG_ADDR) begin
      cfg_q <= pwdata[5:0];
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hF) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  // Cycles from one strobe to the next.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 4'h0;
    end else begin
      gap_q <= bit_strobe ? 4'h1 : ((gap_q == 4'hF) ? gap_q : gap_q + 4'h1);
    end
  end
  // Address decode and the expected strobe spacing.
  assign map = paddr inside {lcc_pkg::CHAN_CFG_ADDR, lcc_pkg::IRQ_STAT_ADDR,
                             lcc_pkg::IRQ_MASK_ADDR, lcc_pkg::LIVE_ADDR};
  assign div = cfg_q[2] ? 4'(DIV_E3) : (cfg_q[1] ? 4'(DIV_STS1) : 4'(DIV_DS3));
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_err_decode: assert property (pready |-> pslverr == !map)
    else $error("pslverr decode wrong");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_unmapped_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_cfg_readback: assert property (pready && !pwrite && paddr == lcc_pkg::CHAN_CFG_ADDR
    |-> prdata == {26'h0, cfg_q})
    else $error("config readback wrong");
  a_codec_rail: assert property (quiet_q >= 4'h3 |-> codec_enable == cfg_q[0])
    else $error("codec enable wrong");
  a_analog_loop: assert property (quiet_q >= 4'h3 |->
    analog_loop_enable == (cfg_q[3] && !cfg_q[4]))
    else $error("analog loop wrong");
  a_strobe_rate: assert property (bit_strobe && quiet_q == 4'hF |-> gap_q == div)
    else $error("strobe spacing wrong");
  a_line_hold: assert property ($changed(line_tx_pos) || $changed(line_tx_neg)
    |-> $past(bit_strobe))
    else $error("line output moved off strobe");
  a_strobe_pulse: assert property (bit_strobe |=> !bit_strobe)
    else $error("strobe too long");
endmodule
bind lcc_top lcc_sva #(.DIV_DS3(DIV_DS3), .DIV_STS1(DIV_STS1), .DIV_E3(DIV_E3)) sva_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .line_tx_pos(line_tx_pos), .line_tx_neg(line_tx_neg), .codec_enable(codec_enable),
  .analog_loop_enable(analog_loop_enable), .bit_strobe(bit_strobe));

// file: lcc_tb.sv
// Self-checking bench for the line channel control block.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp=%0h got=%0h", nm, e, g); end end
module testbench;
  localparam int unsigned DDS = 3, DST = 2, DE3 = 4;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, err, host = 1, rxp = 0, rxn = 0, cv = 0, inj = 0;
  logic tpos, tneg, ltp, ltn, rpos, nrv, codec, aloop, bs, bs_d = 0, cap_on = 0;
  logic [5:0] c;
  int n_fail = 0, check_count = 0, seed = 10524, ec, ec0, i, k, p;
  bit q[$];
  lcc_top #(.DIV_DS3(DDS), .DIV_STS1(DST), .DIV_E3(DE3), .LOCK_BITS(4)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .host_mode_in(host), .tx_pos_data_in(tpos), .tx_neg_data_in(tneg),
    .line_rx_pos_in(rxp), .line_rx_neg_in(rxn), .code_violation_in(cv),
    .line_tx_pos(ltp), .line_tx_neg(ltn), .rx_pos_data_out(rpos),
    .neg_rail_or_violation_out(nrv), .codec_enable(codec), .analog_loop_enable(aloop),
    .bit_strobe(bs));
  lcc_far far_u (.pclk(pclk), .presetn(presetn), .bit_strobe(bs),
    .neg_rail_or_violation_out(nrv), .tx_pos_data_in(tpos), .tx_neg_data_in(tneg),
    .err_count(ec));
  // Clock.
  initial forever #5 pclk = ~pclk;
  // Line loops back with optional bit flips; transmitted marks are captured.
  always @(posedge pclk) begin
    rxp <= inj ? ~(ltp | ltn) : ltp;
    rxn <= ltn & ~inj;
    bs_d <= bs;
    if (cap_on && bs_d) q.push_back(ltp | ltn);
  end
  // One APB transfer; waits for pready with no bound of its own.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reads a register and compares it.
  task rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask
  // Cycles between two strobes.
  task meas(output int t);
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (bs !== 1'b1 && t < 50);
  endtask
  // Expected strobe spacing for a configuration.
  function automatic int period(input logic [5:0] v);
    return v[2] ? DE3 : (v[1] ? DST : DDS);
  endfunction
  // Bits that break the recurrence with the two given taps.
  function automatic int viol(input int a, input int b);
    int v = 0;
    for (int j = b; j < q.size(); j++) if (q[j] != (q[j-a] ^ q[j-b])) v++;
    return v;
  endfunction
  // Verdict and end of run.
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Watchdog.
  initial begin
    repeat (60000) @(posedge pclk);
    n_fail++;
    stop_test;
  end
  // Main sequence.
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(lcc_pkg::CHAN_CFG_ADDR, 32'h0, "cfg_reset");
    rdchk(lcc_pkg::IRQ_STAT_ADDR, 32'h0, "stat_reset");
    rdchk(lcc_pkg::IRQ_MASK_ADDR, 32'h0, "mask_reset");
    apb(1'b1, lcc_pkg::CHAN_CFG_ADDR, 32'hFFFFFFFF);
    rdchk(lcc_pkg::CHAN_CFG_ADDR, 32'h3F, "cfg_upper");
    rdchk(8'h04, 32'h0, "unmapped_data");
    `CHK("unmapped_err", 1'b1, err)
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(lcc_pkg::CHAN_CFG_ADDR, 32'h0, "cfg_rereset");
    $display("test registers done");
    // Random rate, rail and loop settings, each rate and loop code forced once.
    for (i = 0; i < 12; i++) begin
      k = $random(seed);
      if (i < 4) k[2:1] = i[1:0];
      if (i < 4) k[4:3] = i[1:0];
      k[5] = 1'b0;
      apb(1'b1, lcc_pkg::CHAN_CFG_ADDR, {26'h0, k[5:0]});
      meas(p);
      meas(p);
      `CHK("strobe_period", period(k[5:0]), p)
      `CHK("codec", k[0], codec)
      `CHK("analog_loop", k[3] & ~k[4], aloop)
      if (k[4:3] == 2'b11) `CHK("rx_digital", ltp, rpos)
    end
    $display("test rates done");
    // Pattern test for each rate, then one inserted error.
    for (i = 0; i < 3; i++) begin
      c = (i == 2) ? 6'h24 : ((i == 1) ? 6'h22 : 6'h20);
      apb(1'b1, lcc_pkg::CHAN_CFG_ADDR, {26'h0, c});
      q.delete();
      repeat (20) @(posedge pclk);
      cap_on <= 1'b1;
      repeat (500) @(posedge pclk);
      cap_on <= 1'b0;
      `CHK("prbs_live", 1'b1, q.sum() with (int'(item)) > 0)
      if (i == 2) `CHK("prbs23", 1'b1, viol(18, 23) == 0 || viol(5, 23) == 0)
      else `CHK("prbs15", 1'b1, viol(14, 15) == 0 || viol(1, 15) == 0)
      rdchk(lcc_pkg::LIVE_ADDR, 32'h7, "live_locked");
      apb(1'b1, lcc_pkg::IRQ_MASK_ADDR, (i == 1) ? 32'h0 : 32'h1);
      apb(1'b1, lcc_pkg::IRQ_STAT_ADDR, 32'h7);
      ec0 = ec;
      @(posedge pclk);
      inj <= 1'b1;
      repeat (period(c)) @(posedge pclk);
      inj <= 1'b0;
      repeat (150) @(posedge pclk);
      `CHK("err_tally", 1'b1, ec > ec0)
      apb(1'b0, lcc_pkg::IRQ_STAT_ADDR, 32'h0);
      `CHK("stat_err", 1'b1, rd[0])
      `CHK("irq_masked", (i != 1), irq)
      apb(1'b1, lcc_pkg::IRQ_STAT_ADDR, 32'h7);
      rdchk(lcc_pkg::IRQ_STAT_ADDR, 32'h0, "stat_clear");
      `CHK("irq_clear", 1'b0, irq)
    end
    $display("test pattern done");
    apb(1'b1, lcc_pkg::CHAN_CFG_ADDR, 32'h0);
    apb(1'b0, lcc_pkg::LIVE_ADDR, 32'h0);
    `CHK("pattern_off", 1'b0, rd[2])
    host <= 1'b0;
    apb(1'b1, lcc_pkg::CHAN_CFG_ADDR, 32'h20);
    repeat (10) @(posedge pclk);
    apb(1'b0, lcc_pkg::LIVE_ADDR, 32'h0);
    `CHK("strap_mode", 2'b00, rd[2:1])
    host <= 1'b1;
    apb(1'b1, lcc_pkg::CHAN_CFG_ADDR, 32'h01);
    apb(1'b1, lcc_pkg::IRQ_MASK_ADDR, 32'h2);
    ec0 = ec;
    cv <= 1'b1;
    repeat (20) @(posedge pclk);
    cv <= 1'b0;
    repeat (20) @(posedge pclk);
    `CHK("violation_out", 1'b1, ec > ec0)
    apb(1'b0, lcc_pkg::IRQ_STAT_ADDR, 32'h0);
    `CHK("stat_viol", 1'b1, rd[1])
    `CHK("irq_viol", 1'b1, irq)
    $display("test single rail done");
    stop_test;
  end
endmodule

// file: lcc_top.sv
// Channel control register with pattern test, loop-back and rate selection.
`timescale 1ns/10ps
module lcc_top #(
  parameter int unsigned DIV_DS3 = 3,
  parameter int unsigned DIV_STS1 = 2,
  parameter int unsigned DIV_E3 = 4,
  parameter int unsigned LOCK_BITS = 32
) (
  // APB clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt.
  output logic irq,
  // Control mode strap, high under host register control.
  input wire logic host_mode_in,
  // System-side transmit data.
  input wire logic tx_pos_data_in,
  input wire logic tx_neg_data_in,
  // Line-side receive data and decoder violation flag.
  input wire logic line_rx_pos_in,
  input wire logic line_rx_neg_in,
  input wire logic code_violation_in,
  // Line-side transmit data.
  output logic line_tx_pos,
  output logic line_tx_neg,
  // System-side receive data.
  output logic rx_pos_data_out,
  output logic neg_rail_or_violation_out,
  // Line section controls.
  output logic codec_enable,
  output logic analog_loop_enable,
  output logic bit_strobe
);

  initial begin
    if (DIV_DS3 < 2 || DIV_DS3 > 255 || DIV_STS1 < 2 || DIV_STS1 > 255 ||
        DIV_E3 < 2 || DIV_E3 > 255) begin
      $error("lcc_top: rate dividers must lie between 2 and 255");
    end
  end

  logic [lcc_pkg::CFG_W-1:0] cfg_q;
  logic [lcc_pkg::IRQ_W-1:0] stat_q;
  logic [lcc_pkg::IRQ_W-1:0] mask_q;
  logic [lcc_pkg::IRQ_W-1:0] events;
  logic [lcc_pkg::NPIN-1:0] pin_raw;
  logic [lcc_pkg::NPIN-1:0] pin_s1_q;
  logic [lcc_pkg::NPIN-1:0] pin_s2_q;
  logic [lcc_pkg::NPIN-1:0] pin_s3_q;
  logic [lcc_pkg::NPIN-1:0] pin_q;
  logic [7:0] div_q;
  logic [7:0] div_end;
  logic tick_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic irq_q;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] rd_word;
  logic [lcc_pkg::IRQ_W-1:0] w1c;
  lcc_pkg::lcc_rate_e rate;
  lcc_pkg::lcc_loop_e loop_mode;
  logic pat_active;
  logic gen_bit;
  logic chk_bit;
  logic pat_err;
  logic pat_locked;
  logic lock_prev_q;
  logic mark_par_q;
  logic tx_src_pos;
  logic tx_src_neg;
  logic line_tx_pos_q;
  logic line_tx_neg_q;
  logic rx_pos_q;
  logic rx_neg_q;
  logic analog_q;

  // Gather the pins that come from outside the clock domain.
  assign pin_raw[lcc_pkg::PIN_TXP] = tx_pos_data_in;
  assign pin_raw[lcc_pkg::PIN_TXN] = tx_neg_data_in;
  assign pin_raw[lcc_pkg::PIN_RXP] = line_rx_pos_in;
  assign pin_raw[lcc_pkg::PIN_RXN] = line_rx_neg_in;
  assign pin_raw[lcc_pkg::PIN_VIOL] = code_violation_in;
  assign pin_raw[lcc_pkg::PIN_HOST] = host_mode_in;

  // Three-stage synchroniser per pin; a change is accepted once stages two and three agree.
  for (genvar i = 0; i < lcc_pkg::NPIN; i++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_s1_q[i] <= 1'b0;
        pin_s2_q[i] <= 1'b0;
        pin_s3_q[i] <= 1'b0;
        pin_q[i] <= 1'b0;
      end else begin
        pin_s1_q[i] <= pin_raw[i];
        pin_s2_q[i] <= pin_s1_q[i];
        pin_s3_q[i] <= pin_s2_q[i];
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pin_q[i] <= pin_s3_q[i];
        end
      end
    end
  end

  // Rate decode: E3 overrides the STS-1 bit.
  always_comb begin
    if (cfg_q[lcc_pkg::BIT_E3]) begin
      rate = lcc_pkg::RATE_E3;
    end else if (cfg_q[lcc_pkg::BIT_STS1]) begin
      rate = lcc_pkg::RATE_STS1;
    end else begin
      rate = lcc_pkg::RATE_DS3;
    end
  end

  // Loop-back decode from the local and remote loop bits.
  always_comb begin
    case ({cfg_q[lcc_pkg::BIT_LOCAL_LOOP], cfg_q[lcc_pkg::BIT_REMOTE_LOOP]})
      2'b01: loop_mode = lcc_pkg::LOOP_REMOTE;
      2'b10: loop_mode = lcc_pkg::LOOP_ANALOG;
      2'b11: loop_mode = lcc_pkg::LOOP_DIGITAL;
      default: loop_mode = lcc_pkg::LOOP_NONE;
    endcase
  end

  // Bit period divider length follows the selected rate.
  always_comb begin
    case (rate)
      lcc_pkg::RATE_E3: div_end = 8'(DIV_E3 - 1);
      lcc_pkg::RATE_STS1: div_end = 8'(DIV_STS1 - 1);
      default: div_end = 8'(DIV_DS3 - 1);
    endcase
  end

  // Divider produces a one-cycle bit strobe.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 8'h00;
      tick_q <= 1'b0;
    end else if (div_q >= div_end) begin
      div_q <= 8'h00;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 8'h01;
      tick_q <= 1'b0;
    end
  end

  // Pattern test runs only when enabled and the part is under host control.
  assign pat_active = cfg_q[lcc_pkg::BIT_PAT] && pin_q[lcc_pkg::PIN_HOST];

  // Checker input is the data arriving at the receive side of the loop.
  always_comb begin
    if (loop_mode == lcc_pkg::LOOP_DIGITAL) begin
      chk_bit = tx_src_pos | tx_src_neg;
    end else if (cfg_q[lcc_pkg::BIT_RAIL]) begin
      chk_bit = pin_q[lcc_pkg::PIN_RXP];
    end else begin
      chk_bit = pin_q[lcc_pkg::PIN_RXP] | pin_q[lcc_pkg::PIN_RXN];
    end
  end

  lcc_prbs #(
    .LOCK_BITS(LOCK_BITS)
  ) u_prbs (
    .pclk(pclk),
    .presetn(presetn),
    .enable(pat_active),
    .long_seq(rate == lcc_pkg::RATE_E3),
    .bit_tick(tick_q),
    .gen_bit(gen_bit),
    .rx_bit(chk_bit),
    .err_q(pat_err),
    .locked(pat_locked)
  );

  // Transmit source: pattern replaces system data; dual-rail pattern uses alternate marks.
  always_comb begin
    if (pat_active) begin
      if (cfg_q[lcc_pkg::BIT_RAIL]) begin
        tx_src_pos = gen_bit;
        tx_src_neg = 1'b0;
      end else begin
        tx_src_pos = gen_bit && !mark_par_q;
        tx_src_neg = gen_bit && mark_par_q;
      end
    end else if (cfg_q[lcc_pkg::BIT_RAIL]) begin
      tx_src_pos = pin_q[lcc_pkg::PIN_TXP];
      tx_src_neg = 1'b0;
    end else begin
      tx_src_pos = pin_q[lcc_pkg::PIN_TXP];
      tx_src_neg = pin_q[lcc_pkg::PIN_TXN];
    end
  end

  // Line transmit and system receive data move once per bit period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_tx_pos_q <= 1'b0;
      line_tx_neg_q <= 1'b0;
      rx_pos_q <= 1'b0;
      rx_neg_q <= 1'b0;
      mark_par_q <= 1'b0;
    end else if (tick_q) begin
      if (pat_active && gen_bit) begin
        mark_par_q <= !mark_par_q;
      end
      if (loop_mode == lcc_pkg::LOOP_REMOTE) begin
        line_tx_pos_q <= pin_q[lcc_pkg::PIN_RXP];
        line_tx_neg_q <= pin_q[lcc_pkg::PIN_RXN];
      end else begin
        line_tx_pos_q <= tx_src_pos;
        line_tx_neg_q <= tx_src_neg;
      end
      if (loop_mode == lcc_pkg::LOOP_DIGITAL) begin
        rx_pos_q <= tx_src_pos;
      end else begin
        rx_pos_q <= pin_q[lcc_pkg::PIN_RXP];
      end
      if (cfg_q[lcc_pkg::BIT_RAIL]) begin
        rx_neg_q <= pin_q[lcc_pkg::PIN_VIOL];
      end else if (pat_active) begin
        rx_neg_q <= pat_err;
      end else if (loop_mode == lcc_pkg::LOOP_DIGITAL) begin
        rx_neg_q <= tx_src_neg;
      end else begin
        rx_neg_q <= pin_q[lcc_pkg::PIN_RXN];
      end
    end
  end

  // Analog loop control is registered so the pin never glitches.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_q <= 1'b0;
    end else begin
      analog_q <= (loop_mode == lcc_pkg::LOOP_ANALOG);
    end
  end

  // APB decode; the slave answers with one wait state.
  assign wr_en = psel && penable && pwrite && pready_q;
  assign rd_en = psel && penable && !pwrite && !pready_q;
  assign addr_ok = (paddr == lcc_pkg::CHAN_CFG_ADDR) || (paddr == lcc_pkg::IRQ_STAT_ADDR) ||
                   (paddr == lcc_pkg::IRQ_MASK_ADDR) || (paddr == lcc_pkg::LIVE_ADDR);

  // Read multiplexer; unused high bits read as zero.
  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr)
      lcc_pkg::CHAN_CFG_ADDR: rd_word[lcc_pkg::CFG_W-1:0] = cfg_q;
      lcc_pkg::IRQ_STAT_ADDR: rd_word[lcc_pkg::IRQ_W-1:0] = stat_q;
      lcc_pkg::IRQ_MASK_ADDR: rd_word[lcc_pkg::IRQ_W-1:0] = mask_q;
      lcc_pkg::LIVE_ADDR: begin
        rd_word[lcc_pkg::LIVE_LOCK] = pat_locked;
        rd_word[lcc_pkg::LIVE_HOST] = pin_q[lcc_pkg::PIN_HOST];
        rd_word[lcc_pkg::LIVE_PAT_ACT] = pat_active;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Handshake, read data and error response.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (psel && penable && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= !addr_ok;
      if (rd_en) begin
        prdata_q <= rd_word;
      end
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Channel configuration; only the six defined bits are stored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= lcc_pkg::CFG_RESET;
    end else if (wr_en && paddr == lcc_pkg::CHAN_CFG_ADDR) begin
      cfg_q <= pwdata[lcc_pkg::CFG_W-1:0];
    end
  end

  // Interrupt mask.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= lcc_pkg::IRQ_RESET;
    end else if (wr_en && paddr == lcc_pkg::IRQ_MASK_ADDR) begin
      mask_q <= pwdata[lcc_pkg::IRQ_W-1:0];
    end
  end

  // Events: a pattern error bit, a code violation bit, a change of lock.
  assign events[lcc_pkg::IRQ_PAT_ERR] = tick_q && pat_err && !cfg_q[lcc_pkg::BIT_RAIL];
  assign events[lcc_pkg::IRQ_VIOL] = tick_q && pin_q[lcc_pkg::PIN_VIOL] &&
                                     cfg_q[lcc_pkg::BIT_RAIL];
  assign events[lcc_pkg::IRQ_LOCK_CHG] = pat_locked != lock_prev_q;
  assign w1c = (wr_en && paddr == lcc_pkg::IRQ_STAT_ADDR) ? pwdata[lcc_pkg::IRQ_W-1:0] :
               lcc_pkg::IRQ_RESET;

  // Sticky status; a new event wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= lcc_pkg::IRQ_RESET;
      lock_prev_q <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~w1c) | events;
      lock_prev_q <= pat_locked;
    end
  end

  // Level interrupt from unmasked status.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  // Outputs straight from flip-flops.
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign line_tx_pos = line_tx_pos_q;
  assign line_tx_neg = line_tx_neg_q;
  assign rx_pos_data_out = rx_pos_q;
  assign neg_rail_or_violation_out = rx_neg_q;
  assign codec_enable = cfg_q[lcc_pkg::BIT_RAIL];
  assign analog_loop_enable = analog_q;
  assign bit_strobe = tick_q;

endmodule
